/* File: hw/sst_regs.svh */
// Constants for the nibble, skip, table-read and XOR execution block
`ifndef SST_REGS_SVH
`define SST_REGS_SVH

// Instruction word layout seen by the decoder
`define SST_OPC_HI 15
`define SST_OPC_LO 12
`define SST_BIT_HI 10
`define SST_BIT_LO 8
`define SST_IMM_HI 7
`define SST_IMM_LO 0

// Operation class codes in the instruction word
`define SST_OPC_NIB 4'h1
`define SST_OPC_SKN 4'h2
`define SST_OPC_CSK 4'h3
`define SST_OPC_BSK 4'h4
`define SST_OPC_TBC 4'h5
`define SST_OPC_TBL 4'h6
`define SST_OPC_XWM 4'h7
`define SST_OPC_XMM 4'h8
`define SST_OPC_XIM 4'h9

// Table reads on the last page use this page number
`define SST_LAST_PAGE 8'hFF

// Reset values
`define SST_WR_RST 8'h00
`define SST_TH_RST 8'h00
`define SST_ZF_RST 1'b0

`endif

/* File: hw/sst_pkg.sv */
// Types shared by the execution block and its decoder
package sst_pkg;

   typedef enum logic [3:0]
   {
      SST_OP_NONE = 4'h0,
      SST_OP_NIB_XCHG = 4'h1,
      SST_OP_SKIP_NULL = 4'h2,
      SST_OP_COPY_SKIP = 4'h3,
      SST_OP_BIT_SKIP = 4'h4,
      SST_OP_TBL_CUR = 4'h5,
      SST_OP_TBL_LAST = 4'h6,
      SST_OP_XOR_WM = 4'h7,
      SST_OP_XOR_MEM = 4'h8,
      SST_OP_XOR_IMM = 4'h9
   } sst_op_t;

   // Gray along run -> table -> run and run -> dummy -> run
   typedef enum logic [1:0]
   {
      SST_ST_RUN = 2'b00,
      SST_ST_TBL = 2'b01,
      SST_ST_DUMMY = 2'b10
   } sst_state_t;

endpackage

/* File: hw/sst_dec_if.sv */
// Interface between the execution block and its instruction decoder
`timescale 1ns/1ns
interface sst_dec_if;
   import sst_pkg::*;
   logic [15:0] instr;
   sst_op_t op;
   logic [2:0] bit_sel;
   logic [7:0] imm;
   modport dec (input instr, output op, output bit_sel, output imm);
   modport exe (output instr, input op, input bit_sel, input imm);
endinterface

/* File: hw/sst_decode.sv */
// Instruction word decoder for the execution block
`timescale 1ns/1ns
`include "sst_regs.svh"
module sst_decode
(
   sst_dec_if.dec dif
);
   import sst_pkg::*;

   function automatic sst_op_t sst_op_of(input logic [3:0] code);
      sst_op_t op;
      op = SST_OP_NONE;
      unique case (code)
         `SST_OPC_NIB: op = SST_OP_NIB_XCHG;
         `SST_OPC_SKN: op = SST_OP_SKIP_NULL;
         `SST_OPC_CSK: op = SST_OP_COPY_SKIP;
         `SST_OPC_BSK: op = SST_OP_BIT_SKIP;
         `SST_OPC_TBC: op = SST_OP_TBL_CUR;
         `SST_OPC_TBL: op = SST_OP_TBL_LAST;
         `SST_OPC_XWM: op = SST_OP_XOR_WM;
         `SST_OPC_XMM: op = SST_OP_XOR_MEM;
         `SST_OPC_XIM: op = SST_OP_XOR_IMM;
         default: op = SST_OP_NONE;
      endcase
      return op;
   endfunction

   always_comb
   begin
      dif.op = sst_op_of(dif.instr[`SST_OPC_HI:`SST_OPC_LO]);
      dif.bit_sel = dif.instr[`SST_BIT_HI:`SST_BIT_LO];
      dif.imm = dif.instr[`SST_IMM_HI:`SST_IMM_LO];
   end

endmodule

/* File: hw/sst_exec.sv */
// Execution of nibble exchange, zero skips, table reads and XOR
// Function
// - Nibble exchange of memory byte into working register
// - Skip next instruction when memory byte zero
// - Taken skip flushes prefetch, adds dummy cycle
// - Copy byte to working register, skip if zero
// - Skip next instruction when selected bit zero
// - Current-page ROM word to memory and latch
// - Last-page ROM word to memory and latch
// - Working register XOR memory into working register
// - Memory XOR working register back into memory
// - Working register XOR immediate into working register
`timescale 1ns/1ns
`include "sst_regs.svh"
module sst_exec
(
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_instr_valid,
   input wire logic [15:0] i_instr,
   input wire logic [7:0] i_mem_rdata,
   input wire logic [7:0] i_table_pointer,
   input wire logic [7:0] i_pc_page,
   input wire logic [15:0] i_rom_data,
   input wire logic i_wr_load,
   input wire logic [7:0] i_wr_data,
   output logic [7:0] o_working_register,
   output logic o_flag_zero,
   output logic [7:0] o_table_high_latch,
   output logic o_mem_we,
   output logic [7:0] o_mem_wdata,
   output logic o_rom_re,
   output logic [15:0] o_rom_addr,
   output logic o_flush,
   output logic o_busy
);
   import sst_pkg::*;

   logic rst_meta;
   logic rst_n;
   sst_dec_if dif ();

   sst_state_t st_reg;
   sst_state_t st_next;
   logic [7:0] wr_reg;
   logic [7:0] wr_next;
   logic zf_reg;
   logic zf_next;
   logic [7:0] th_reg;
   logic [7:0] th_next;
   logic we_reg;
   logic we_next;
   logic [7:0] wd_reg;
   logic [7:0] wd_next;
   logic re_reg;
   logic re_next;
   logic [15:0] ra_reg;
   logic [15:0] ra_next;
   logic fl_reg;
   logic fl_next;
   logic busy_reg;
   logic busy_next;

   logic take;
   logic [7:0] xr_wm;
   logic [7:0] xr_imm;
   logic mem_null;
   logic do_skip;

   // Release of reset is synchronised; assertion is immediate
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   assign dif.instr = i_instr;

   sst_decode sst_decode_inst
   (
      .dif (dif)
   );

   // Intake stalls while the dummy cycle, table read or write-back runs
   assign take = i_instr_valid && (st_reg == SST_ST_RUN) && !busy_reg;
   assign xr_wm = wr_reg ^ i_mem_rdata;
   assign xr_imm = wr_reg ^ dif.imm;
   assign mem_null = (i_mem_rdata == 8'h00);

   always_comb
   begin
      st_next = st_reg;
      wr_next = wr_reg;
      zf_next = zf_reg;
      th_next = th_reg;
      we_next = 1'b0;
      wd_next = wd_reg;
      re_next = 1'b0;
      ra_next = ra_reg;
      fl_next = 1'b0;
      do_skip = 1'b0;
      if (i_wr_load && !take)
      begin
         wr_next = i_wr_data;
      end
      unique case (st_reg)
         SST_ST_RUN:
         begin
            if (take)
            begin
               unique case (dif.op)
                  SST_OP_NIB_XCHG:
                  begin
                     wr_next = {i_mem_rdata[3:0], i_mem_rdata[7:4]};
                  end
                  SST_OP_SKIP_NULL:
                  begin
                     do_skip = mem_null;
                  end
                  SST_OP_COPY_SKIP:
                  begin
                     wr_next = i_mem_rdata;
                     do_skip = mem_null;
                  end
                  SST_OP_BIT_SKIP:
                  begin
                     do_skip = !i_mem_rdata[dif.bit_sel];
                  end
                  SST_OP_TBL_CUR:
                  begin
                     ra_next = {i_pc_page, i_table_pointer};
                     re_next = 1'b1;
                     st_next = SST_ST_TBL;
                  end
                  SST_OP_TBL_LAST:
                  begin
                     ra_next = {`SST_LAST_PAGE, i_table_pointer};
                     re_next = 1'b1;
                     st_next = SST_ST_TBL;
                  end
                  SST_OP_XOR_WM:
                  begin
                     wr_next = xr_wm;
                     zf_next = (xr_wm == 8'h00);
                  end
                  SST_OP_XOR_MEM:
                  begin
                     we_next = 1'b1;
                     wd_next = xr_wm;
                     zf_next = (xr_wm == 8'h00);
                  end
                  SST_OP_XOR_IMM:
                  begin
                     wr_next = xr_imm;
                     zf_next = (xr_imm == 8'h00);
                  end
                  SST_OP_NONE:
                  begin
                     st_next = SST_ST_RUN;
                  end
               endcase
               if (do_skip)
               begin
                  fl_next = 1'b1;
                  st_next = SST_ST_DUMMY;
               end
            end
         end
         SST_ST_TBL:
         begin
            // ROM answers combinationally while the read strobe is high
            wd_next = i_rom_data[7:0];
            th_next = i_rom_data[15:8];
            we_next = 1'b1;
            st_next = SST_ST_RUN;
         end
         SST_ST_DUMMY:
         begin
            st_next = SST_ST_RUN;
         end
         default:
         begin
            st_next = SST_ST_RUN;
         end
      endcase
      // Memory write-back stalls intake so the next read sees it
      busy_next = (st_next != SST_ST_RUN) || we_next;
   end

   always_ff @(posedge i_clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg <= SST_ST_RUN;
         wr_reg <= `SST_WR_RST;
         zf_reg <= `SST_ZF_RST;
         th_reg <= `SST_TH_RST;
         we_reg <= 1'b0;
         wd_reg <= 8'h00;
         re_reg <= 1'b0;
         ra_reg <= 16'h0000;
         fl_reg <= 1'b0;
         busy_reg <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
         wr_reg <= wr_next;
         zf_reg <= zf_next;
         th_reg <= th_next;
         we_reg <= we_next;
         wd_reg <= wd_next;
         re_reg <= re_next;
         ra_reg <= ra_next;
         fl_reg <= fl_next;
         busy_reg <= busy_next;
      end
   end

   assign o_working_register = wr_reg;
   assign o_flag_zero = zf_reg;
   assign o_table_high_latch = th_reg;
   assign o_mem_we = we_reg;
   assign o_mem_wdata = wd_reg;
   assign o_rom_re = re_reg;
   assign o_rom_addr = ra_reg;
   assign o_flush = fl_reg;
   assign o_busy = busy_reg;

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence s_flush_dummy;
      o_flush && o_busy ##1 !o_busy && !o_flush;
   endsequence

   sequence s_tbl_fetch;
      o_rom_re && o_busy ##1 o_mem_we && !o_rom_re;
   endsequence

   a_nib_xchg_wr: assert property (
      take && dif.op == SST_OP_NIB_XCHG |=>
      o_working_register == {$past(i_mem_rdata[3:0]),
         $past(i_mem_rdata[7:4])} && $stable(o_flag_zero) && !o_mem_we)
      else $error("nibble exchange result wrong");

   a_null_skip: assert property (
      take && dif.op == SST_OP_SKIP_NULL && mem_null |=> s_flush_dummy)
      else $error("null skip not taken");

   a_nonnull_run: assert property (
      take && dif.op == SST_OP_SKIP_NULL && !mem_null |=>
      !o_flush && !o_busy && $stable(o_flag_zero))
      else $error("skip taken on nonzero byte");

   a_flush_one_dummy: assert property (
      o_flush |-> s_flush_dummy)
      else $error("flush without single dummy cycle");

   a_copy_skip: assert property (
      take && dif.op == SST_OP_COPY_SKIP |=>
      o_working_register == $past(i_mem_rdata) &&
      o_flush == ($past(i_mem_rdata) == 8'h00) && $stable(o_flag_zero))
      else $error("copy skip wrong");

   a_bit_skip: assert property (
      take && dif.op == SST_OP_BIT_SKIP |=>
      o_flush == !$past(i_mem_rdata[dif.bit_sel]))
      else $error("bit skip decision wrong");

   a_tbl_current: assert property (
      take && dif.op == SST_OP_TBL_CUR |=>
      o_rom_addr == {$past(i_pc_page), $past(i_table_pointer)}
      ##0 s_tbl_fetch ##0
      o_mem_wdata == $past(i_rom_data[7:0]) &&
      o_table_high_latch == $past(i_rom_data[15:8]))
      else $error("current page table read wrong");

   a_tbl_last: assert property (
      take && dif.op == SST_OP_TBL_LAST |=>
      o_rom_addr == {`SST_LAST_PAGE, $past(i_table_pointer)}
      ##0 s_tbl_fetch ##0
      o_mem_wdata == $past(i_rom_data[7:0]) &&
      o_table_high_latch == $past(i_rom_data[15:8]) && $stable(o_flag_zero))
      else $error("last page table read wrong");

   a_xor_work: assert property (
      take && dif.op == SST_OP_XOR_WM |=>
      o_working_register == ($past(o_working_register) ^
         $past(i_mem_rdata)) && !o_mem_we)
      else $error("register XOR memory wrong");

   a_xor_memory: assert property (
      take && dif.op == SST_OP_XOR_MEM |=>
      o_mem_we && o_busy && $stable(o_working_register) &&
      o_mem_wdata == ($past(o_working_register) ^ $past(i_mem_rdata)))
      else $error("memory XOR wrong");

   a_xor_immediate: assert property (
      take && dif.op == SST_OP_XOR_IMM |=>
      o_working_register == ($past(o_working_register) ^ $past(dif.imm)))
      else $error("immediate XOR wrong");

   a_zero_flag: assert property (
      take && (dif.op == SST_OP_XOR_WM || dif.op == SST_OP_XOR_MEM ||
         dif.op == SST_OP_XOR_IMM) |=>
      o_flag_zero == (($past(dif.op) == SST_OP_XOR_MEM) ?
         (o_mem_wdata == 8'h00) : (o_working_register == 8'h00)))
      else $error("zero flag disagrees with XOR result");

endmodule

/* File: test/sst_exec_test.sv */
// Self-checking bench for the nibble, skip, table-read and XOR block
`timescale 1ns/1ns
`include "sst_regs.svh"
module sst_exec_test;
   logic i_clk_sys;
   logic i_arst_n;
   logic i_instr_valid;
   logic [15:0] i_instr;
   logic [7:0] i_mem_rdata;
   logic [7:0] i_table_pointer;
   logic [7:0] i_pc_page;
   logic [15:0] i_rom_data;
   logic i_wr_load;
   logic [7:0] i_wr_data;
   logic [7:0] o_working_register;
   logic o_flag_zero;
   logic [7:0] o_table_high_latch;
   logic o_mem_we;
   logic [7:0] o_mem_wdata;
   logic o_rom_re;
   logic [15:0] o_rom_addr;
   logic o_flush;
   logic o_busy;
   int n_mismatch;
   int tests_run;
   int i;

   sst_exec sst_exec_inst
   (
      .i_clk_sys(i_clk_sys),
      .i_arst_n(i_arst_n),
      .i_instr_valid(i_instr_valid),
      .i_instr(i_instr),
      .i_mem_rdata(i_mem_rdata),
      .i_table_pointer(i_table_pointer),
      .i_pc_page(i_pc_page),
      .i_rom_data(i_rom_data),
      .i_wr_load(i_wr_load),
      .i_wr_data(i_wr_data),
      .o_working_register(o_working_register),
      .o_flag_zero(o_flag_zero),
      .o_table_high_latch(o_table_high_latch),
      .o_mem_we(o_mem_we),
      .o_mem_wdata(o_mem_wdata),
      .o_rom_re(o_rom_re),
      .o_rom_addr(o_rom_addr),
      .o_flush(o_flush),
      .o_busy(o_busy)
   );

   initial
   begin
      i_clk_sys = 1'b0;
      forever #4 i_clk_sys = ~i_clk_sys;
   end

   task automatic wrap_up();
      if (n_mismatch == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Inputs always move 1 ns after the rising edge
   task automatic step();
      @(posedge i_clk_sys);
      #1;
   endtask

   task automatic load_wr(input logic [7:0] v);
      i_wr_load = 1'b1;
      i_wr_data = v;
      step();
      i_wr_load = 1'b0;
   endtask

   // Returns in the first cycle after the taking edge
   task automatic issue(input logic [3:0] cls, input logic [2:0] bsel,
      input logic [7:0] imm, input logic [7:0] mem);
      int n;
      n = 0;
      while (o_busy !== 1'b0)
      begin
         step();
         n++;
         if (n > 20)
         begin
            n_mismatch++;
            $display("ERROR busy expected 0 seen %b", o_busy);
            wrap_up();
         end
      end
      i_instr_valid = 1'b1;
      i_instr = {cls, 1'b0, bsel, imm};
      i_mem_rdata = mem;
      step();
      i_instr_valid = 1'b0;
      // Stale memory byte must not be reused
      i_mem_rdata = ~mem;
   endtask

   task automatic chk_skip(input logic taken);
      chk("flush", {15'h0000, taken}, o_flush);
      chk("busy", {15'h0000, taken}, o_busy);
      if (taken)
      begin
         step();
         chk("flush", 16'h0000, o_flush);
         chk("busy", 16'h0000, o_busy);
      end
   endtask

   task automatic t_xor();
      load_wr(8'hF0);
      issue(`SST_OPC_XWM, 3'h0, 8'h00, 8'h0F);
      chk("wr", 16'h00FF, o_working_register);
      chk("zflag", 16'h0000, o_flag_zero);
      issue(`SST_OPC_XWM, 3'h0, 8'h00, 8'hFF);
      chk("wr", 16'h0000, o_working_register);
      chk("zflag", 16'h0001, o_flag_zero);
      issue(`SST_OPC_XIM, 3'h0, 8'hA5, 8'h3C);
      chk("wr", 16'h00A5, o_working_register);
      chk("zflag", 16'h0000, o_flag_zero);
      issue(`SST_OPC_XIM, 3'h0, 8'hA5, 8'hC3);
      chk("wr", 16'h0000, o_working_register);
      chk("zflag", 16'h0001, o_flag_zero);
      load_wr(8'h5A);
      issue(`SST_OPC_XMM, 3'h0, 8'h00, 8'h0F);
      chk("mem_we", 16'h0001, o_mem_we);
      chk("wdata", 16'h0055, o_mem_wdata);
      chk("zflag", 16'h0000, o_flag_zero);
      chk("wr", 16'h005A, o_working_register);
      step();
      chk("mem_we", 16'h0000, o_mem_we);
      issue(`SST_OPC_XMM, 3'h0, 8'h00, 8'h5A);
      chk("wdata", 16'h0000, o_mem_wdata);
      chk("zflag", 16'h0001, o_flag_zero);
   endtask

   // Flag left high by the XOR scenario must survive these
   task automatic t_nibble();
      issue(`SST_OPC_NIB, 3'h0, 8'h00, 8'h3C);
      chk("wr", 16'h00C3, o_working_register);
      chk("zflag", 16'h0001, o_flag_zero);
      chk("mem_we", 16'h0000, o_mem_we);
      issue(`SST_OPC_NIB, 3'h0, 8'h00, 8'hF1);
      chk("wr", 16'h001F, o_working_register);
   endtask

   task automatic t_skip();
      issue(`SST_OPC_SKN, 3'h0, 8'h00, 8'h00);
      chk_skip(1'b1);
      chk("zflag", 16'h0001, o_flag_zero);
      issue(`SST_OPC_SKN, 3'h0, 8'h00, 8'h80);
      chk_skip(1'b0);
      issue(`SST_OPC_CSK, 3'h0, 8'h00, 8'h00);
      chk("wr", 16'h0000, o_working_register);
      chk_skip(1'b1);
      issue(`SST_OPC_CSK, 3'h0, 8'h00, 8'h5A);
      chk("wr", 16'h005A, o_working_register);
      chk_skip(1'b0);
      chk("zflag", 16'h0001, o_flag_zero);
      for (i = 0; i < 8; i++)
      begin
         issue(`SST_OPC_BSK, i[2:0], 8'h00, ~(8'h01 << i));
         chk_skip(1'b1);
         issue(`SST_OPC_BSK, i[2:0], 8'h00, 8'h01 << i);
         chk_skip(1'b0);
      end
   endtask

   task automatic t_table(input logic [3:0] cls, input logic [7:0] page,
      input logic [15:0] rom);
      // ROM word appears only once the read strobe is up
      i_rom_data = ~rom;
      issue(cls, 3'h0, 8'h00, 8'h77);
      i_rom_data = rom;
      chk("rom_re", 16'h0001, o_rom_re);
      chk("rom_addr", {page, 8'h34}, o_rom_addr);
      chk("busy", 16'h0001, o_busy);
      step();
      // ROM answer is only guaranteed while the read strobe is up
      i_rom_data = ~rom;
      chk("rom_re", 16'h0000, o_rom_re);
      chk("mem_we", 16'h0001, o_mem_we);
      chk("wdata", {8'h00, rom[7:0]}, o_mem_wdata);
      chk("tbl_hi", {8'h00, rom[15:8]}, o_table_high_latch);
      step();
      chk("busy", 16'h0000, o_busy);
      chk("mem_we", 16'h0000, o_mem_we);
      chk("zflag", 16'h0001, o_flag_zero);
   endtask

   initial
   begin
      n_mismatch = 0;
      tests_run = 0;
      i_arst_n = 1'b0;
      i_instr_valid = 1'b0;
      i_instr = 16'h0000;
      i_mem_rdata = 8'h00;
      i_table_pointer = 8'h34;
      i_pc_page = 8'h12;
      i_rom_data = 16'h0000;
      i_wr_load = 1'b0;
      i_wr_data = 8'h00;
      repeat (12) @(posedge i_clk_sys);
      #1;
      i_arst_n = 1'b1;
      repeat (3) step();
      t_xor();
      t_nibble();
      t_skip();
      t_table(`SST_OPC_TBC, 8'h12, 16'hA55A);
      t_table(`SST_OPC_TBL, `SST_LAST_PAGE, 16'h3CC3);
      wrap_up();
   end

   // Hang guard
   initial
   begin
      repeat (5000) @(posedge i_clk_sys);
      n_mismatch++;
      wrap_up();
   end
endmodule
